// ---- pmic_ctrl.sv ----
// Summary of operation
// RULE_01: host sets stop bit then halts itself
// RULE_02: stop wakes on enabled lin/wake input
// RULE_03: stop keeps limited supply, stages off
// RULE_04: sleep bit kills supply, reset low
// RULE_05: sleep wake unmaskable, records its cause
// RULE_06: normal request: reset high, wait timeout
// RULE_07: no power-stage-on in time means sleep
// RULE_08: run enables stages, lin, monitoring
// RULE_09: seven masked sources pulse interrupt line
// RULE_10: undervoltage sets flag outside stop/sleep
// RULE_11: overvoltage sets flag outside stop/sleep
// RULE_12: overtemperature sets flag outside stop/sleep
// RULE_13: lin rising edge after long dominant
// RULE_14: stage fault sets flag outside stop/sleep
// RULE_15: hall state edges set flag in run
// RULE_16: wake input edges set flag in run
// RULE_17: flags clear by writing one only
// RULE_18: clear ignored while condition persists
// RULE_19: host sets power-stage-on after stop wake
// RULE_20: fixed-length low pulse on new enabled flag
module pmic_ctrl #(
    parameter longint normal_request_cycles = pmic_pkg::normal_request_cycles
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic clock_enable,
    input wire logic test_mode,
    input wire pmic_pkg::pmic_access_type access,
    output logic [7:0] read_data,
    input wire pmic_pkg::pmic_sense_type sense,
    input wire logic lin_rx,
    input wire logic wake_input_state,
    input wire logic hall_input_state,
    input wire logic hall_irq_capable,
    output logic irq_n,
    output logic host_reset_n,
    output pmic_pkg::pmic_power_type power,
    output pmic_pkg::pmic_mode_type mode
);

    // registers
    logic [7:0] mask;
    logic [7:0] flags;
    logic [2:0] control;
    logic [1:0] wake_cause;
    // timeout counter, wide enough for the full 80 ms count
    logic [31:0] request_count;
    // lin dominant length and edge history
    logic [15:0] dominant_count;
    logic lin_last;
    logic wake_last;
    logic hall_last;
    // interrupt pulse timing
    logic [3:0] pulse_count;
    // events this cycle
    logic [7:0] events;
    logic [7:0] clear_req;
    logic [7:0] held;
    logic lin_wake_seen;
    logic wake_edge;
    logic hall_edge;
    logic active_detect;
    logic new_irq;
    logic flag_write;

    assign flag_write = access.write && access.addr == pmic_pkg::event_flag_register_addr;
    // analog detectors are powered down in stop and sleep
    assign active_detect = mode == pmic_pkg::pmic_run || mode == pmic_pkg::pmic_normal_request;
    assign wake_edge = wake_input_state != wake_last;
    assign hall_edge = hall_input_state != hall_last;
    // recessive (high) after long dominant phase
    assign lin_wake_seen = lin_rx && !lin_last && dominant_count >= pmic_pkg::wake_filter_cycles;

    // event collection
    always_comb
    begin
        events = 8'h00;
        // RULE_10 low supply
        events[pmic_pkg::undervoltage_bit] = active_detect && sense.undervoltage_event;
        // RULE_11 high supply
        events[pmic_pkg::overvoltage_bit] = active_detect && sense.overvoltage_event;
        // RULE_12 hot die
        events[pmic_pkg::overtemp_bit] = active_detect && sense.overtemp_event;
        // RULE_14 stage fault
        events[pmic_pkg::stage_fail_bit] = active_detect && sense.stage_fail_detect;
        // RULE_13 lin wake edge, stop mode only
        events[pmic_pkg::lin_wake_bit] = mode == pmic_pkg::pmic_stop && lin_wake_seen
            && mask[pmic_pkg::lin_wake_bit];
        // RULE_15 hall edges in run
        events[pmic_pkg::hall_input_bit] = mode == pmic_pkg::pmic_run && hall_irq_capable && hall_edge;
        // RULE_16 wake input edges in run, or as stop wake source
        events[pmic_pkg::wake_input_bit] = wake_edge && (mode == pmic_pkg::pmic_run
            || (mode == pmic_pkg::pmic_stop && mask[pmic_pkg::wake_input_bit]));
    end

    // level conditions that block a clear
    always_comb
    begin
        held = 8'h00;
        // RULE_18 persisting condition holds flag
        held[pmic_pkg::undervoltage_bit] = sense.undervoltage_event;
        held[pmic_pkg::overtemp_bit] = sense.overtemp_event;
        held[pmic_pkg::overvoltage_bit] = sense.overvoltage_event;
        clear_req = flag_write ? (access.wdata & ~held) : 8'h00;
    end

    // edge history for inputs
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lin_last <= 1'b1;
            wake_last <= 1'b0;
            hall_last <= 1'b0;
        end
        else if (clock_enable)
        begin
            lin_last <= lin_rx;
            wake_last <= wake_input_state;
            hall_last <= hall_input_state;
        end
    end

    // dominant phase length, saturating
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            dominant_count <= 16'h0000;
        else if (clock_enable)
        begin
            if (lin_rx)
                dominant_count <= 16'h0000;
            else if (dominant_count != 16'hffff)
                dominant_count <= dominant_count + 16'h0001;
        end
    end

    // flag register: set wins over clear
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            flags <= pmic_pkg::flag_reset;
        // RULE_17 write one clears, set wins
        else if (clock_enable)
            flags <= (flags & ~clear_req) | events;
    end

    // mask register, cleared by arst_n only, kept over a sleep wake
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            mask <= pmic_pkg::mask_reset;
        // RULE_09 masks writable, zero after reset
        else if (clock_enable && access.write && access.addr == pmic_pkg::mask_register_addr)
            mask <= access.wdata;
    end

    // system control: mode request bits
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            control <= 3'h0;
        else if (clock_enable)
        begin
            if (access.write && access.addr == pmic_pkg::system_control_addr)
                control <= access.wdata[2:0];
            // stop request is consumed on entry so a wake returns to run, not back to stop
            else if (mode == pmic_pkg::pmic_stop)
                control[pmic_pkg::stop_pos] <= 1'b0;
            // a sleep wake behaves as power-on: control cleared
            else if (mode == pmic_pkg::pmic_sleep && (lin_wake_seen || wake_edge))
                control <= 3'h0;
        end
    end

    // mode sequencer
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mode <= pmic_pkg::pmic_normal_request;
            request_count <= 32'h0;
        end
        else if (clock_enable)
        begin
            unique case (mode)
                pmic_pkg::pmic_normal_request:
                begin
                    // RULE_06 wait for power-stage-on
                    if (control[pmic_pkg::power_stage_on_pos])
                        mode <= pmic_pkg::pmic_run;
                    // RULE_07 fail-safe sleep unless test mode
                    else if (!test_mode && request_count >= 32'(normal_request_cycles - 1))
                        mode <= pmic_pkg::pmic_sleep;
                    else if (!test_mode)
                        request_count <= request_count + 32'h1;
                end
                pmic_pkg::pmic_run:
                begin
                    // RULE_04 sleep takes priority
                    if (control[pmic_pkg::sleep_pos])
                        mode <= pmic_pkg::pmic_sleep;
                    // RULE_01 host stop request
                    else if (control[pmic_pkg::stop_pos])
                        mode <= pmic_pkg::pmic_stop;
                end
                pmic_pkg::pmic_stop:
                begin
                    // RULE_19 host restores power-stage-on after wake
                    if (control[pmic_pkg::sleep_pos])
                        mode <= pmic_pkg::pmic_sleep;
                    else if (control[pmic_pkg::power_stage_on_pos] && |flags)
                        mode <= pmic_pkg::pmic_run;
                end
                pmic_pkg::pmic_sleep:
                begin
                    // RULE_05 any wake restarts as power-on
                    if (lin_wake_seen || wake_edge)
                    begin
                        mode <= pmic_pkg::pmic_normal_request;
                        request_count <= 32'h0;
                    end
                end
                default:
                    mode <= pmic_pkg::pmic_normal_request;
            endcase
        end
    end

    // wake cause flags, write one to clear
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            wake_cause <= 2'b00;
        else if (clock_enable)
        begin
            // RULE_05 record sleep wake cause
            if (mode == pmic_pkg::pmic_sleep)
                wake_cause <= wake_cause | {wake_edge, lin_wake_seen};
            else if (access.write && access.addr == pmic_pkg::reset_status_addr)
                wake_cause <= wake_cause & ~access.wdata[1:0];
        end
    end

    // new enabled flag starts a pulse
    assign new_irq = |(events & ~flags & mask);

    // interrupt pulse generator
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pulse_count <= 4'h0;
            irq_n <= 1'b1;
        end
        else if (clock_enable)
        begin
            // RULE_20 fixed-length low pulse
            if (new_irq && pulse_count == 4'h0)
            begin
                pulse_count <= pmic_pkg::irq_pulse_cycles;
                irq_n <= 1'b0;
            end
            else if (pulse_count > 4'h1)
                pulse_count <= pulse_count - 4'h1;
            else
            begin
                pulse_count <= 4'h0;
                irq_n <= 1'b1;
            end
        end
    end

    // power enables and reset pin, registered
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            power <= '0;
            host_reset_n <= 1'b0;
        end
        else if (clock_enable)
        begin
            // RULE_08 run enables stages, lin, monitoring and full regulator
            power.power_stages_on <= mode == pmic_pkg::pmic_run;
            power.lin_on <= mode == pmic_pkg::pmic_run;
            power.monitoring_on <= mode == pmic_pkg::pmic_run;
            // RULE_03 stop keeps limited supply
            power.regulator_limited <= mode == pmic_pkg::pmic_stop;
            // RULE_04 sleep turns supply off, reset low
            power.regulator_on <= mode != pmic_pkg::pmic_sleep;
            host_reset_n <= mode != pmic_pkg::pmic_sleep;
        end
    end

    // register read port
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            read_data <= 8'h00;
        else if (clock_enable && access.read)
        begin
            unique case (access.addr)
                pmic_pkg::mask_register_addr: read_data <= mask;
                pmic_pkg::event_flag_register_addr: read_data <= flags;
                pmic_pkg::system_control_addr: read_data <= {5'h00, control};
                pmic_pkg::reset_status_addr: read_data <= {6'h00, wake_cause};
                default: read_data <= 8'h00;
            endcase
        end
    end

endmodule // pmic_ctrl

// ---- pmic_pkg.sv ----
package pmic_pkg;

    // register indices on the internal register port
    localparam logic [3:0] mask_register_addr = 4'h9;
    localparam logic [3:0] event_flag_register_addr = 4'ha;
    localparam logic [3:0] system_control_addr = 4'hc;
    localparam logic [3:0] reset_status_addr = 4'hd;

    // event flag / mask bit positions (shared layout)
    localparam int wake_input_bit = 0;
    localparam int hall_input_bit = 1;
    localparam int lin_wake_bit = 2;
    localparam int overtemp_bit = 3;
    localparam int undervoltage_bit = 4;
    localparam int overvoltage_bit = 5;
    localparam int stage_fail_bit = 6;

    // system control bit positions
    localparam int power_stage_on_pos = 0;
    localparam int stop_pos = 1;
    localparam int sleep_pos = 2;

    // reset status bit positions for wake causes
    localparam int lin_wake_reset_pos = 0;
    localparam int wake_input_reset_pos = 1;

    // reset values
    localparam logic [7:0] mask_reset = 8'h00;
    localparam logic [7:0] flag_reset = 8'h00;
    localparam logic [7:0] control_reset = 8'h00;

    // timing
    localparam longint clock_hz = 250000000;
    localparam longint normal_request_timeout_ms = 80;
    localparam longint normal_request_cycles = (normal_request_timeout_ms * clock_hz) / 1000;
    localparam longint wake_filter_time_ns = 100;
    localparam logic [15:0] wake_filter_cycles = 16'((wake_filter_time_ns * clock_hz + 999999999) / 1000000000);
    localparam logic [3:0] irq_pulse_cycles = 4'h8;

    // power modes
    typedef enum logic [2:0] {pmic_normal_request, pmic_run, pmic_stop, pmic_sleep} pmic_mode_type;

    // register access from the link
    typedef struct packed {
        logic write;
        logic read;
        logic [3:0] addr;
        logic [7:0] wdata;
    } pmic_access_type;

    // analog indications
    typedef struct packed {
        logic undervoltage_event;
        logic overvoltage_event;
        logic overtemp_event;
        logic stage_fail_detect;
    } pmic_sense_type;

    // block enables towards the analog side
    typedef struct packed {
        logic regulator_on;
        logic regulator_limited;
        logic monitoring_on;
        logic power_stages_on;
        logic lin_on;
    } pmic_power_type;

endpackage

// ---- pmic_ctrl_assertions.sv ----
module pmic_ctrl_assertions #(
    parameter longint normal_request_cycles = 50
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic clock_enable,
    input wire logic test_mode,
    input wire pmic_pkg::pmic_access_type access,
    input wire logic [7:0] read_data,
    input wire logic irq_n,
    input wire logic host_reset_n,
    input wire pmic_pkg::pmic_power_type power,
    input wire pmic_pkg::pmic_mode_type mode
);
    timeunit 1ns;
    timeprecision 100ps;
    // shadow of the mask, as written by the host
    logic [7:0] mask;
    // cycles spent waiting in normal request
    longint wait_cnt;
    // shadow follows only taken writes
    always_ff @(posedge clock or negedge arst_n)
        if (!arst_n)
            mask <= 8'h00;
        else if (clock_enable && access.write && access.addr == pmic_pkg::mask_register_addr)
            mask <= access.wdata;
    // restarts outside normal request and in test mode, so it only bounds the wait
    always_ff @(posedge clock or negedge arst_n)
        if (!arst_n)
            wait_cnt <= 0;
        else
            wait_cnt <= (mode == pmic_pkg::pmic_normal_request && !test_mode) ? wait_cnt + 1 : 0;
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    chk_pulse_len: assert property ($fell(irq_n) |-> !irq_n [*8] ##1 irq_n)
        else $error("irq pulse length wrong");
    chk_masked_irq: assert property ($fell(irq_n) |-> $past(mask) != 8'h00)
        else $error("irq with all sources masked");
    chk_mask_read: assert property (clock_enable && access.read && !access.write
        && access.addr == pmic_pkg::mask_register_addr |=> read_data == mask)
        else $error("mask readback wrong");
    // enables and reset pin follow the mode one cycle later, so look at the mode before
    chk_sleep_state: assert property ($past(mode) == pmic_pkg::pmic_sleep |-> !host_reset_n
        && !power.regulator_on && !power.power_stages_on)
        else $error("sleep outputs wrong");
    chk_stop_state: assert property ($past(mode) == pmic_pkg::pmic_stop |-> host_reset_n && power.regulator_limited
        && !power.power_stages_on && !power.monitoring_on && !power.lin_on)
        else $error("stop outputs wrong");
    chk_run_state: assert property ($past(mode) == pmic_pkg::pmic_run |-> power.power_stages_on
        && power.lin_on && power.regulator_on)
        else $error("run outputs wrong");
    chk_request_state: assert property (mode == pmic_pkg::pmic_normal_request && $past(arst_n)
        && $past(mode) == pmic_pkg::pmic_normal_request |-> host_reset_n
        && !power.power_stages_on && !power.lin_on)
        else $error("normal request outputs wrong");
    chk_request_timeout: assert property (wait_cnt <= normal_request_cycles + 4)
        else $error("normal request outlived its timeout");
endmodule // pmic_ctrl_assertions
bind pmic_ctrl pmic_ctrl_assertions #(.normal_request_cycles(normal_request_cycles)) u_chk (
    .clock(clock), .arst_n(arst_n), .clock_enable(clock_enable), .test_mode(test_mode),
    .access(access), .read_data(read_data), .irq_n(irq_n), .host_reset_n(host_reset_n),
    .power(power), .mode(mode));

// ---- pmic_host_model.sv ----
module pmic_host_model (
    input wire logic clock,
    output pmic_pkg::pmic_access_type access,
    input wire logic [7:0] read_data
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle link at time zero
    initial access = '0;
    // request held across its taking edge, answer taken after it
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
        access <= '{write: w, read: !w, addr: a, wdata: d};
        @(posedge clock);
        // released lines show the inverse, never the stale value
        access <= '{write: 1'b0, read: 1'b0, addr: ~a, wdata: ~d};
        #1 q = read_data;
    endtask
    // stop together with power-stage-on, then the host idles
    task automatic stop_entry();
        logic [7:0] q;
        acc(1'b1, pmic_pkg::system_control_addr, 8'h03, q);
    endtask
endmodule // pmic_host_model

// ---- pmic_ctrl_test.sv ----
module pmic_ctrl_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [3:0] ef = pmic_pkg::event_flag_register_addr;
    localparam logic [3:0] mk = pmic_pkg::mask_register_addr;
    localparam logic [3:0] sc = pmic_pkg::system_control_addr;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic test_mode = 1'b0;
    pmic_pkg::pmic_sense_type sense = '0;
    logic lin_rx = 1'b1;
    logic wake_st = 1'b0;
    logic hall_st = 1'b0;
    logic hall_cap = 1'b1;
    pmic_pkg::pmic_access_type access;
    logic [7:0] read_data;
    logic irq_n;
    logic host_reset_n;
    pmic_pkg::pmic_power_type power;
    pmic_pkg::pmic_mode_type mode;
    int err_count = 0;
    int checks_done = 0;
    // random mask seed
    logic [7:0] m = 8'h2e;
    logic [7:0] q;
    // flag bit of each sense input, lowest struct bit first
    int fb[4] = '{pmic_pkg::stage_fail_bit, pmic_pkg::overtemp_bit, pmic_pkg::overvoltage_bit,
        pmic_pkg::undervoltage_bit};
    always #2 clock = ~clock;
    pmic_ctrl #(.normal_request_cycles(50)) u_pmic_ctrl (.clock(clock), .arst_n(arst_n), .clock_enable(1'b1),
        .test_mode(test_mode), .access(access), .read_data(read_data), .sense(sense), .lin_rx(lin_rx),
        .wake_input_state(wake_st), .hall_input_state(hall_st), .hall_irq_capable(hall_cap),
        .irq_n(irq_n), .host_reset_n(host_reset_n), .power(power), .mode(mode));
    pmic_host_model u_pmic_host_model (.clock(clock), .access(access), .read_data(read_data));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // pulse length a new flag should give under a mask
    function automatic logic [7:0] exp_len(input logic [7:0] msk, input int b);
        return msk[b] ? 8'h08 : 8'h00;
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // lets the edge updates land before looking
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk_mode(input pmic_pkg::pmic_mode_type e);
        chk(8'(mode), 8'(e));
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        u_pmic_host_model.acc(1'b0, a, 8'h00, q);
        chk(q, exp);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        u_pmic_host_model.acc(1'b1, a, d, q);
    endtask
    // counts low interrupt cycles, then reads the flags
    task automatic see(input logic [7:0] len, input logic [7:0] flags);
        logic [7:0] n;
        n = 8'h00;
        repeat (14)
        begin
            tick(1);
            n = n + 8'(!irq_n);
        end
        chk(n, len);
        rd(ef, flags);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        tick(1);
        rd(mk, 8'h00);
        rd(ef, 8'h00);
        wr(sc, 8'h01);
        tick(1);
        chk_mode(pmic_pkg::pmic_run);
        $display("run entry done");
        // each sense source under a random mask
        for (int i = 0; i < 4; i++)
        begin
            m = lfsr(m);
            wr(mk, m);
            sense[i] <= 1'b1;
            see(exp_len(m, fb[i]), 8'h01 << fb[i]);
            wr(ef, 8'h00);
            rd(ef, 8'h01 << fb[i]);
            // clear while held is tried on the three held sources only; stage fail is not in held and is re-set while high
            if (i > 0)
            begin
                wr(ef, 8'hff);
                rd(ef, 8'h01 << fb[i]);
            end
            sense[i] <= 1'b0;
            wr(ef, 8'hff);
            rd(ef, 8'h00);
        end
        $display("sense done");
        wr(mk, 8'h03);
        wake_st <= 1'b1;
        see(8'h08, 8'h01);
        hall_st <= 1'b1;
        see(8'h08, 8'h03);
        wr(ef, 8'hff);
        // hall edges ignored when the input cannot interrupt
        hall_cap <= 1'b0;
        hall_st <= 1'b0;
        see(8'h00, 8'h00);
        hall_cap <= 1'b1;
        $display("edges done");
        wr(mk, 8'h04);
        u_pmic_host_model.stop_entry();
        tick(1);
        chk_mode(pmic_pkg::pmic_stop);
        // undervoltage in stop must not flag
        sense <= 4'h8;
        lin_rx <= 1'b0;
        tick(40);
        sense <= '0;
        lin_rx <= 1'b1;
        see(8'h08, 8'h04);
        chk_mode(pmic_pkg::pmic_run);
        $display("stop done");
        wr(ef, 8'hff);
        wr(sc, 8'h04);
        tick(1);
        chk_mode(pmic_pkg::pmic_sleep);
        // reset pin is registered from the mode, one cycle behind
        tick(1);
        chk(8'(host_reset_n), 8'h00);
        wake_st <= 1'b0;
        tick(6);
        chk_mode(pmic_pkg::pmic_normal_request);
        rd(pmic_pkg::reset_status_addr, 8'h02);
        tick(60);
        chk_mode(pmic_pkg::pmic_sleep);
        test_mode <= 1'b1;
        wake_st <= 1'b1;
        tick(70);
        chk_mode(pmic_pkg::pmic_normal_request);
        $display("sleep done");
        summarize();
    end
    // cuts a hang short
    initial
    begin
        repeat (5000) @(posedge clock);
        err_count++;
        summarize();
    end
endmodule // pmic_ctrl_test
